// ===== sxd_alu.sv
`timescale 1ns/100ps
`include "sxd_cfg.svh"

module sxd_alu
(
    input  wire sxd_pkg::sxd_op_t op,
    input  wire logic [7:0]       acc,
    input  wire logic [7:0]       file_data,
    input  wire logic [7:0]       literal_value,
    output logic      [7:0]       result,
    output logic                  zero_upd,
    output logic                  zero_val
);
    import sxd_pkg::*;

    function automatic logic [7:0] nib_swap(input logic [7:0] v);
        nib_swap = {v[3:0], v[7:4]};
    endfunction

    always_comb
    begin
        result   = file_data;
        zero_upd = 1'b0;
        case (op)
            SXD_OP_SWAP:
            begin
                result = nib_swap(file_data); // RULE1
            end
            SXD_OP_XORL:
            begin
                result   = acc ^ literal_value; // RULE4
                zero_upd = 1'b1;
            end
            SXD_OP_XORF:
            begin
                result   = acc ^ file_data; // RULE5
                zero_upd = 1'b1;
            end
            default:
            begin
                result = file_data;
            end
        endcase
        zero_val = (result == 8'h00); // RULE6
    end

endmodule // sxd_alu

// ===== sxd_cfg.svh
`ifndef SXD_CFG_SVH
`define SXD_CFG_SVH

// ----------------------------------------
// Operand ranges and encodings
// ----------------------------------------
`define SXD_FILE_ADDR_MAX   7'h7F
`define SXD_DIR_SEL_A       3'h5
`define SXD_DIR_SEL_B       3'h6
`define SXD_DIR_SEL_C       3'h7
`define SXD_DEST_ACC        1'h0
`define SXD_DEST_FILE       1'h1
`define SXD_ACC_RESET       8'h00
`define SXD_DIR_RESET       8'hFF
`define SXD_FILE_DEPTH      128

`endif

// ===== sxd_exec.sv
`timescale 1ns/100ps
`include "sxd_cfg.svh"

// How it works
// RULE1: Nibble swap exchanges upper and lower nibbles; no flag changes.
// RULE2: Destination bit 0 writes accumulator, 1 writes file register 0..127.
// RULE3: Direction load copies accumulator to port A, B, C direction for 5, 6, 7.
// RULE4: Xor literal: accumulator xor 8-bit literal into accumulator; only zero flag.
// RULE5: Xor file: accumulator xor file register, routed by destination; only zero flag.
// RULE6: Both xor forms set zero flag when result is zero, else clear.
module sxd_exec
(
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                instr_valid,
    input  wire sxd_pkg::sxd_instr_t instr,
    output sxd_pkg::sxd_dir_t        dir_out,
    output logic [7:0]               acc_out,
    output logic                     zero_flag,
    output logic [7:0]               file_rd_data
);
    import sxd_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] file_reg [0:`SXD_FILE_DEPTH-1];
    logic [7:0] acc_reg;
    logic       zero_reg;
    sxd_dir_t   dir_reg;
    logic [7:0] alu_result;
    logic       zero_upd;
    logic       zero_val;
    logic [7:0] file_data;
    logic       exec_op;
    logic       to_file;

    // ----------------------------------------
    // Operand decode
    // ----------------------------------------
    // Only these ops touch acc or file; unknown codes must leave both alone
    function automatic logic is_alu_op(input sxd_op_t op);
        is_alu_op = (op == SXD_OP_SWAP) || (op == SXD_OP_XORL) || (op == SXD_OP_XORF);
    endfunction

    assign file_data = file_reg[instr.file_addr];
    assign exec_op   = instr_valid && is_alu_op(instr.op);
    assign to_file   = exec_op && (instr.op != SXD_OP_XORL) && (instr.dest_select == `SXD_DEST_FILE);

    sxd_alu u_alu
    (
        .op            (instr.op),
        .acc           (acc_reg),
        .file_data     (file_data),
        .literal_value (instr.literal_value),
        .result        (alu_result),
        .zero_upd      (zero_upd),
        .zero_val      (zero_val)
    );

    // ----------------------------------------
    // Accumulator
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            acc_reg <= `SXD_ACC_RESET;
        else if (exec_op && !to_file)
            acc_reg <= alu_result; // RULE2
    end

    // ----------------------------------------
    // File registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < `SXD_FILE_DEPTH; i++)
                file_reg[i] <= 8'h00;
        end
        else if (to_file)
            file_reg[instr.file_addr] <= alu_result; // RULE2
    end

    // ----------------------------------------
    // Zero flag
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            zero_reg <= 1'b0;
        else if (instr_valid && zero_upd)
            zero_reg <= zero_val; // RULE6
    end

    // ----------------------------------------
    // Direction registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            dir_reg <= {3{`SXD_DIR_RESET}};
        else if (instr_valid && instr.op == SXD_OP_DIRLD)
        begin
            case (instr.file_addr[2:0])
                `SXD_DIR_SEL_A: dir_reg.port_a_direction <= acc_reg; // RULE3
                `SXD_DIR_SEL_B: dir_reg.port_b_direction <= acc_reg; // RULE3
                `SXD_DIR_SEL_C: dir_reg.port_c_direction <= acc_reg; // RULE3
                default:        dir_reg <= dir_reg;
            endcase
        end
    end

    assign acc_out      = acc_reg;
    assign zero_flag    = zero_reg;
    assign dir_out      = dir_reg;
    assign file_rd_data = file_data;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_swap_issue;
        instr_valid && instr.op == SXD_OP_SWAP;
    endsequence

    sequence s_dirld_issue;
        instr_valid && instr.op == SXD_OP_DIRLD;
    endsequence

    sequence s_xor_issue;
        instr_valid && (instr.op == SXD_OP_XORL || instr.op == SXD_OP_XORF);
    endsequence

    property p_swap_file;
        logic [7:0] v;
        @(posedge core_clk) disable iff (!rstn)
        (s_swap_issue and instr.dest_select, v = file_data)
        |=> file_reg[$past(instr.file_addr)] == {v[3:0], v[7:4]};
    endproperty

    a_swap_nibbles: assert property (p_swap_file) else $error("swap result wrong"); // RULE1

    a_swap_noflag: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
        s_swap_issue |=> $stable(zero_reg)) else $error("swap changed zero flag");

    a_dest_acc: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
        (instr_valid && instr.op == SXD_OP_XORF && !instr.dest_select)
        |=> acc_reg == ($past(acc_reg) ^ $past(file_data))) else $error("acc destination wrong");

    a_dest_file: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
        (instr_valid && instr.op == SXD_OP_XORF && instr.dest_select)
        |=> $stable(acc_reg)) else $error("file destination touched acc");

    a_dir_load_a: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
        (instr_valid && instr.op == SXD_OP_DIRLD && instr.file_addr[2:0] == `SXD_DIR_SEL_A)
        |=> dir_reg.port_a_direction == $past(acc_reg) && $stable(zero_reg))
        else $error("port a direction load wrong");

    a_dir_load_c: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
        (instr_valid && instr.op == SXD_OP_DIRLD && instr.file_addr[2:0] == `SXD_DIR_SEL_C)
        |=> dir_reg.port_c_direction == $past(acc_reg) && $stable(dir_reg.port_b_direction))
        else $error("port c direction load wrong");

    a_xorl_result: assert property (@(posedge core_clk) disable iff (!rstn) // RULE4
        (instr_valid && instr.op == SXD_OP_XORL)
        |=> acc_reg == ($past(acc_reg) ^ $past(instr.literal_value))) else $error("xor literal wrong");

    a_xor_zero: assert property (@(posedge core_clk) disable iff (!rstn) // RULE6
        (instr_valid && (instr.op == SXD_OP_XORL || instr.op == SXD_OP_XORF))
        |=> zero_reg == ($past(zero_val))) else $error("zero flag wrong");

    a_xorf_zero: assert property (@(posedge core_clk) disable iff (!rstn) // RULE6
        (instr_valid && instr.op == SXD_OP_XORF && (acc_reg == file_data))
        |=> zero_reg) else $error("xor file zero not set");

    a_xorf_nonzero: assert property (@(posedge core_clk) disable iff (!rstn) // RULE6
        (instr_valid && instr.op == SXD_OP_XORF && (acc_reg != file_data))
        |=> !zero_reg) else $error("xor file zero set on nonzero");

    // ----------------------------------------
    // Destination, operand and hold checks
    // ----------------------------------------
    a_swap_to_acc: assert property (@(posedge core_clk) disable iff (!rstn) // RULE1
        (s_swap_issue and !instr.dest_select)
        |=> acc_reg == {$past(file_data[3:0]), $past(file_data[7:4])}) else $error("swap to acc wrong");

    property p_file_write_xor;
        logic [7:0] v;
        logic [6:0] a;
        @(posedge core_clk) disable iff (!rstn)
        (s_xor_issue and (instr.op == SXD_OP_XORF && instr.dest_select),
            v = acc_reg ^ file_data, a = instr.file_addr)
        |=> file_reg[a] == v;
    endproperty

    a_dest_file_write: assert property (p_file_write_xor) else $error("file destination not written"); // RULE2

    property p_xorl_file_hold;
        logic [7:0] v;
        logic [6:0] a;
        @(posedge core_clk) disable iff (!rstn)
        (s_xor_issue and instr.op == SXD_OP_XORL, v = file_data, a = instr.file_addr)
        |=> file_reg[a] == v;
    endproperty

    a_xorl_no_file: assert property (p_xorl_file_hold) else $error("xor literal wrote file"); // RULE4

    a_dir_load_b: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
        (s_dirld_issue and instr.file_addr[2:0] == `SXD_DIR_SEL_B)
        |=> dir_reg.port_b_direction == $past(acc_reg) && $stable(dir_reg.port_a_direction))
        else $error("port b direction load wrong");

    a_dir_refused: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
        (s_dirld_issue and instr.file_addr[2:0] < `SXD_DIR_SEL_A)
        |=> $stable(dir_reg)) else $error("direction load with bad operand");

    a_dirld_noflag: assert property (@(posedge core_clk) disable iff (!rstn) // RULE3
        s_dirld_issue |=> $stable(zero_reg) && $stable(acc_reg)) else $error("direction load changed acc or flag");

    a_idle_hold: assert property (@(posedge core_clk) disable iff (!rstn) // RULE2
        !(instr_valid && is_alu_op(instr.op)) |=> $stable(acc_reg)) else $error("acc changed without an op");

endmodule // sxd_exec

// ===== sxd_pkg.sv
package sxd_pkg;

    typedef enum logic [2:0]
    {
        SXD_OP_NONE  = 3'h0,
        SXD_OP_SWAP  = 3'h1,
        SXD_OP_XORL  = 3'h3,
        SXD_OP_XORF  = 3'h2,
        SXD_OP_DIRLD = 3'h6
    } sxd_op_t;

    typedef struct packed
    {
        sxd_op_t    op;
        logic [6:0] file_addr;
        logic       dest_select;
        logic [7:0] literal_value;
    } sxd_instr_t;

    typedef struct packed
    {
        logic [7:0] port_a_direction;
        logic [7:0] port_b_direction;
        logic [7:0] port_c_direction;
    } sxd_dir_t;

endpackage

// ===== test_swap_xor_dirload_exec.sv
`timescale 1ns/100ps
module test_swap_xor_dirload_exec;
    import sxd_pkg::*;

    logic       core_clk;
    logic       rstn;
    logic       instr_valid;
    sxd_instr_t instr;
    sxd_dir_t   dir_out;
    logic [7:0] acc_out;
    logic       zero_flag;
    logic [7:0] file_rd_data;
    int         error_cnt;
    int         total_checks;

    sxd_exec dut
    (
        .core_clk     (core_clk),
        .rstn         (rstn),
        .instr_valid  (instr_valid),
        .instr        (instr),
        .dir_out      (dir_out),
        .acc_out      (acc_out),
        .zero_flag    (zero_flag),
        .file_rd_data (file_rd_data)
    );

    // ----------------------------------------
    // Clock, compare and finish
    // ----------------------------------------
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (error_cnt == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One instruction, results settled at the next falling edge
    task automatic run(input sxd_op_t op, input logic [6:0] fa, input logic ds, input logic [7:0] lit);
        @(negedge core_clk);
        instr_valid = 1'b1;
        instr = '{op: op, file_addr: fa, dest_select: ds, literal_value: lit};
        @(negedge core_clk);
        instr_valid = 1'b0;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_xor_lit;
        run(SXD_OP_XORL, 7'h00, 1'b1, 8'hA5);
        chk(acc_out, 8'hA5);
        chk(file_rd_data, 8'h00);
        chk(zero_flag, 1'b0);
        run(SXD_OP_XORL, 7'h00, 1'b0, 8'hA5);
        chk(acc_out, 8'h00);
        chk(zero_flag, 1'b1);
        run(SXD_OP_XORL, 7'h00, 1'b0, 8'hFF);
        chk(zero_flag, 1'b0);
    endtask

    task automatic t_xor_file;
        run(SXD_OP_XORF, 7'h7F, 1'b1, 8'h00);
        chk(file_rd_data, 8'hFF);
        chk(acc_out, 8'hFF);
        run(SXD_OP_XORF, 7'h7F, 1'b0, 8'h00);
        chk(acc_out, 8'h00);
        chk(file_rd_data, 8'hFF);
        chk(zero_flag, 1'b1);
    endtask

    task automatic t_swap;
        run(SXD_OP_XORL, 7'h00, 1'b0, 8'h3C);
        run(SXD_OP_XORF, 7'h12, 1'b1, 8'h00);
        run(SXD_OP_XORF, 7'h12, 1'b0, 8'h00);
        run(SXD_OP_SWAP, 7'h12, 1'b0, 8'h00);
        chk(acc_out, 8'hC3);
        chk(file_rd_data, 8'h3C);
        chk(zero_flag, 1'b1);
        run(SXD_OP_SWAP, 7'h12, 1'b1, 8'h00);
        chk(file_rd_data, 8'hC3);
        chk(acc_out, 8'hC3);
    endtask

    task automatic t_dirload;
        logic [7:0] a;
        sxd_dir_t   exp;
        a = 8'hC3;
        exp = 24'hFFFFFF;
        for (int i = 4; i < 8; i++)
        begin
            a = a ^ 8'(i * 16 + 1);
            run(SXD_OP_XORL, 7'h00, 1'b0, 8'(i * 16 + 1));
            run(SXD_OP_DIRLD, 7'(i), 1'b0, 8'h00);
            if (i == 5) exp.port_a_direction = a;
            if (i == 6) exp.port_b_direction = a;
            if (i == 7) exp.port_c_direction = a;
            chk(dir_out, exp);
            chk(zero_flag, 1'b0);
        end
        // Zero flag set beforehand so a stray flag write would show
        run(SXD_OP_XORL, 7'h00, 1'b0, 8'hC3);
        run(SXD_OP_DIRLD, 7'h05, 1'b0, 8'h00);
        exp.port_a_direction = 8'h00;
        chk(dir_out, exp);
        chk(zero_flag, 1'b1);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        error_cnt = 0;
        total_checks = 0;
        rstn = 1'b0;
        instr_valid = 1'b0;
        instr = '{op: SXD_OP_NONE, file_addr: 7'h00, dest_select: 1'b0, literal_value: 8'h00};
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rstn = 1'b1;
        chk({8'h00, acc_out, 7'h00, zero_flag}, 24'h000000);
        chk(dir_out, 24'hFFFFFF);
        t_xor_lit();
        t_xor_file();
        t_swap();
        t_dirload();
        end_sim();
    end

    initial
    begin
        #100000;
        error_cnt++;
        end_sim();
    end
endmodule // test_swap_xor_dirload_exec
